// ===== design/flash_page_program_control.sv
// flash programming controller: status/control registers and launch logic
`timescale 1ns/1ns
module flash_page_program_control (
	input wire logic MCLK_IN, // core clock, 100 MHz
	input wire logic RESETN_IN, // async system reset, active low
	input wire logic BOOT_ENTRY_IN, // boot ROM entered after reset
	input wire logic EXEC_BOOT_IN, // core is fetching from boot ROM
	input wire logic INSTR_DONE_IN, // pulse at end of each instruction
	input wire logic SFR_WR_IN, // register write strobe
	input wire logic [7:0] SFR_ADDR_IN, // register address
	input wire logic [7:0] SFR_WDATA_IN, // register write data
	output logic [7:0] SFR_RDATA_OUT, // register read data
	input wire logic XDATA_WR_IN, // pointer-form external-data write
	input wire logic [15:0] XDATA_ADDR_IN, // data pointer value
	input wire logic [7:0] XDATA_DATA_IN, // external-data write byte
	input wire logic XRAM_SELECT_IN, // auxiliary internal-xram select
	input wire logic [flash_ctl_pkg::BANK_W-1:0] BANK_OVERRIDE_IN, // bank
	output logic XDATA_TO_LATCH_OUT, // external writes go to latches
	output logic XDATA_TO_XRAM_OUT, // external writes go to internal xram
	output logic CODE_READ_BOOT_OUT, // code reads served by boot ROM
	output logic [2:0] MAP_MODE_OUT, // space mapped into code reads
	output logic PROG_START_OUT, // one-cycle launch pulse to array
	output logic [2:0] PROG_OP_OUT, // operation being run
	output logic [flash_ctl_pkg::PAGE_W-1:0] PROG_PAGE_OUT, // target page
	output logic [flash_ctl_pkg::BANK_W-1:0] PROG_BANK_OUT, // upper bank
	output logic PROG_UPPER_OUT, // target page lies in upper half
	input wire logic ARRAY_DONE_IN, // array finished the operation
	input wire logic [flash_ctl_pkg::LATCH_AW-1:0] LATCH_RD_ADDR_IN, // rd
	output logic [7:0] LATCH_RD_DATA_OUT, // latch byte, next cycle
	input wire logic [7:0] SEC_CURRENT_IN, // present security byte
	input wire logic [7:0] SEC_ERASED_IN, // bits whose space is erased
	output logic [7:0] SEC_VALUE_OUT // security byte to program
);
	import flash_ctl_pkg::*;

	latch_if lat ();

	logic [7:0] control_reg;
	logic redirect_reg;
	logic error_reg;
	logic loaded_reg;
	logic busy_reg;
	logic strap_done_reg;
	seq_state_type seq_reg;
	seq_state_type seq_next;
	logic [2:0] op_reg;
	logic start_reg;
	logic [7:0] sec_value_reg;
	logic [PAGE_W-1:0] page_reg;
	logic [BANK_W-1:0] bank_reg;
	logic upper_reg;
	logic [7:0] rdata_reg;

	logic ctl_wr;
	logic st_wr;
	logic [3:0] nibble;
	flash_mode_type wr_mode;
	logic arm_write;
	logic launch_write;
	logic seq_good;
	logic seq_bad;
	logic op_fire;
	logic latch_reset;
	logic latch_load;
	program_op_type fire_op;

	// map a mode code to the array operation it starts
	function automatic program_op_type mode_to_op(input flash_mode_type m);
		program_op_type op;
		op = OP_NONE;
		unique case (m)
			MODE_USER: op = OP_PAGE;
			MODE_EXTRA: op = OP_EXTRA;
			MODE_ERASE: op = OP_ERASE;
			MODE_LATCH_RST: op = OP_NONE;
			MODE_SECURITY: op = OP_SECURITY;
			MODE_FUSE: op = OP_FUSE;
			MODE_RSV6: op = OP_NONE;
			MODE_RSV7: op = OP_NONE;
		endcase
		return op;
	endfunction : mode_to_op

	// reserved codes run nothing at all
	function automatic logic mode_reserved(input flash_mode_type m);
		return (m == MODE_RSV6) || (m == MODE_RSV7);
	endfunction : mode_reserved

	assign ctl_wr = SFR_WR_IN && (SFR_ADDR_IN == CONTROL_ADDR);
	assign st_wr = SFR_WR_IN && (SFR_ADDR_IN == STATUS_ADDR);
	assign nibble = SFR_WDATA_IN[CT_NIBBLE_HI:CT_NIBBLE_LO];
	assign wr_mode = flash_mode_type'(SFR_WDATA_IN[CT_MODE_HI:0]);
	assign arm_write = ctl_wr && (nibble == NIBBLE_ARM);
	assign launch_write = ctl_wr && (nibble == NIBBLE_LAUNCH);

	// sequence checker: the arming write must be followed directly by
	// the launch write; any other instruction in between spoils it
	always_comb begin
		seq_next = seq_reg;
		seq_good = 1'b0;
		seq_bad = 1'b0;
		if (INSTR_DONE_IN) begin
			unique case (seq_reg)
				SEQ_IDLE: begin
					if (arm_write) begin
						seq_next = SEQ_ARMED;
					end else if (launch_write) begin
						seq_bad = 1'b1;
					end
				end
				SEQ_ARMED: begin
					if (launch_write) begin
						seq_good = 1'b1;
						seq_next = SEQ_IDLE;
					end else begin
						seq_bad = 1'b1;
						seq_next = arm_write ? SEQ_ARMED : SEQ_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			seq_reg <= SEQ_IDLE;
		end else begin
			seq_reg <= seq_next;
		end
	end

	// a correct sequence still does nothing for reserved modes, when
	// nothing is loaded, or while an earlier operation is running
	always_comb begin
		fire_op = mode_to_op(wr_mode);
		op_fire = 1'b0;
		latch_reset = 1'b0;
		if (seq_good && loaded_reg && !busy_reg) begin
			if (wr_mode == MODE_LATCH_RST) begin
				latch_reset = 1'b1;
			end else if (!mode_reserved(wr_mode)) begin
				op_fire = 1'b1;
			end
		end
	end

	// top mode bit selects the serial field: no array page write there
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			op_reg <= OP_NONE;
		end else if (op_fire) begin
			if (wr_mode[CT_MODE_TOP] && fire_op == OP_PAGE) begin
				op_reg <= OP_NONE;
			end else begin
				op_reg <= fire_op;
			end
		end
	end

	// the start pulse lands on the same edge that raises busy
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			start_reg <= 1'b0;
		end else begin
			start_reg <= op_fire;
		end
	end

	// busy follows the array; status writes never reach it
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			busy_reg <= 1'b0;
		end else if (op_fire) begin
			busy_reg <= 1'b1;
		end else if (ARRAY_DONE_IN) begin
			busy_reg <= 1'b0;
		end
	end

	// hardware set wins over a software clear in the same cycle
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			error_reg <= 1'b0;
		end else if (seq_bad) begin
			error_reg <= 1'b1;
		end else if (seq_good && !loaded_reg) begin
			error_reg <= 1'b1;
		end else if (seq_good) begin
			error_reg <= 1'b0;
		end else if (st_wr && !SFR_WDATA_IN[ST_ERROR_BIT]) begin
			error_reg <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			loaded_reg <= 1'b0;
		end else if (latch_load) begin
			loaded_reg <= 1'b1;
		end else if (op_fire || latch_reset) begin
			loaded_reg <= 1'b0;
		end
	end

	// the redirect strap is caught on the first edge after release
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			strap_done_reg <= 1'b0;
		end else begin
			strap_done_reg <= 1'b1;
		end
	end

	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			redirect_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			redirect_reg <= BOOT_ENTRY_IN;
		end else if (st_wr && EXEC_BOOT_IN) begin
			redirect_reg <= SFR_WDATA_IN[ST_REDIRECT_BIT];
		end
	end

	// the whole byte is kept so the launch nibble reads back as well
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			control_reg <= CONTROL_RESET;
		end else if (ctl_wr) begin
			control_reg <= SFR_WDATA_IN;
		end
	end

	// latch loads: only pointer-form writes arrive here, one byte each
	assign latch_load = XDATA_WR_IN && control_reg[CT_MAP_BIT] &&
		!busy_reg;
	assign lat.wr = latch_load;
	assign lat.waddr = XDATA_ADDR_IN[LATCH_AW-1:0];
	assign lat.wdata = XDATA_DATA_IN;
	assign lat.clr = latch_reset;
	assign lat.raddr = LATCH_RD_ADDR_IN;

	// last load decides page and, for the upper half, the bank
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			page_reg <= PAGE_RESET;
			upper_reg <= 1'b0;
			bank_reg <= BANK_RESET;
		end else if (latch_load) begin
			page_reg <= XDATA_ADDR_IN[PAGE_HI:PAGE_LO];
			upper_reg <= XDATA_ADDR_IN[UPPER_HALF_BIT];
			if (XDATA_ADDR_IN[UPPER_HALF_BIT]) begin
				bank_reg <= BANK_OVERRIDE_IN;
			end
		end
	end

	// security byte: a new one only where that space was fully erased
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			sec_value_reg <= ERASED_BYTE;
		end else if (op_fire && wr_mode == MODE_SECURITY) begin
			sec_value_reg <= SEC_CURRENT_IN |
				(LATCH_RD_DATA_OUT & SEC_ERASED_IN);
		end
	end

	// latch reads lag the address by a cycle; the security capture
	// uses whatever byte the read address pointed at the cycle before the launch
	column_latch u_latch (
		.clk_in(MCLK_IN),
		.resetn_in(RESETN_IN),
		.lat(lat.store)
	);

	// status and control read back; unused status bits read as zero
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			rdata_reg <= READ_ZERO;
		end else if (SFR_ADDR_IN == STATUS_ADDR) begin
			rdata_reg <= READ_ZERO;
			rdata_reg[ST_REDIRECT_BIT] <= redirect_reg;
			rdata_reg[ST_ERROR_BIT] <= error_reg;
			rdata_reg[ST_LOADED_BIT] <= loaded_reg;
			rdata_reg[ST_BUSY_BIT] <= busy_reg;
		end else if (SFR_ADDR_IN == CONTROL_ADDR) begin
			rdata_reg <= control_reg;
		end else begin
			rdata_reg <= READ_ZERO;
		end
	end

	// routing outputs, registered so every port comes from a flop
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			XDATA_TO_LATCH_OUT <= 1'b0;
			XDATA_TO_XRAM_OUT <= 1'b0;
			CODE_READ_BOOT_OUT <= 1'b0;
			MAP_MODE_OUT <= MODE_USER;
		end else begin
			XDATA_TO_LATCH_OUT <= control_reg[CT_MAP_BIT];
			XDATA_TO_XRAM_OUT <= XRAM_SELECT_IN &&
				!control_reg[CT_MAP_BIT];
			CODE_READ_BOOT_OUT <= EXEC_BOOT_IN && redirect_reg;
			MAP_MODE_OUT <= control_reg[CT_MODE_HI:0];
		end
	end

	// registered state driven straight onto the ports
	assign SFR_RDATA_OUT = rdata_reg;
	assign PROG_START_OUT = start_reg;
	assign PROG_OP_OUT = op_reg;
	assign PROG_PAGE_OUT = page_reg;
	assign PROG_BANK_OUT = bank_reg;
	assign PROG_UPPER_OUT = upper_reg;
	assign LATCH_RD_DATA_OUT = lat.rdata;
	assign SEC_VALUE_OUT = sec_value_reg;
endmodule : flash_page_program_control

// ===== design/flash_ctl_pkg.sv
// shared constants and types for the flash programming controller
package flash_ctl_pkg;
	localparam logic [7:0] CONTROL_ADDR = 8'hd1;
	localparam logic [7:0] STATUS_ADDR = 8'hd3;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam int ST_REDIRECT_BIT = 7;
	localparam int ST_ERROR_BIT = 2;
	localparam int ST_LOADED_BIT = 1;
	localparam int ST_BUSY_BIT = 0;
	localparam int CT_NIBBLE_HI = 7;
	localparam int CT_NIBBLE_LO = 4;
	localparam int CT_MAP_BIT = 3;
	localparam int CT_MODE_HI = 2;
	localparam int CT_MODE_TOP = 2;
	localparam logic [3:0] NIBBLE_ARM = 4'h5;
	localparam logic [3:0] NIBBLE_LAUNCH = 4'ha;
	localparam int LATCH_BYTES = 128;
	localparam int LATCH_AW = 7;
	localparam int PAGE_W = 8;
	localparam int PAGE_LO = 7;
	localparam int PAGE_HI = 14;
	localparam int UPPER_HALF_BIT = 15;
	localparam int BANK_W = 3;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [BANK_W-1:0] BANK_RESET = 3'h0;
	localparam logic [PAGE_W-1:0] PAGE_RESET = 8'h00;

	typedef enum logic [2:0] {
		MODE_USER = 3'b000,
		MODE_EXTRA = 3'b001,
		MODE_ERASE = 3'b010,
		MODE_LATCH_RST = 3'b011,
		MODE_SECURITY = 3'b100,
		MODE_FUSE = 3'b101,
		MODE_RSV6 = 3'b110,
		MODE_RSV7 = 3'b111
	} flash_mode_type;

	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_PAGE = 3'b001,
		OP_EXTRA = 3'b010,
		OP_ERASE = 3'b011,
		OP_SECURITY = 3'b100,
		OP_FUSE = 3'b101
	} program_op_type;

	typedef enum logic [0:0] {
		SEQ_IDLE = 1'b0,
		SEQ_ARMED = 1'b1
	} seq_state_type;
endpackage : flash_ctl_pkg

// ===== design/latch_if.sv
// carrier between the controller and its column latch buffer
`timescale 1ns/1ns
interface latch_if;
	import flash_ctl_pkg::*;
	logic wr;
	logic [LATCH_AW-1:0] waddr;
	logic [7:0] wdata;
	logic clr;
	logic [LATCH_AW-1:0] raddr;
	logic [7:0] rdata;
	modport owner (output wr, waddr, wdata, clr, raddr, input rdata);
	modport store (input wr, waddr, wdata, clr, raddr, output rdata);
endinterface : latch_if

// ===== design/column_latch.sv
// 128-byte column latch page buffer with per-byte loaded marks
`timescale 1ns/1ns
module column_latch (
	input wire logic clk_in, // core clock
	input wire logic resetn_in, // async reset, active low
	latch_if.store lat // write, clear and read port
);
	import flash_ctl_pkg::*;

	logic [7:0] mem_reg [LATCH_BYTES];
	logic [LATCH_BYTES-1:0] valid_reg;

	// data array needs no reset; the valid marks decide what is seen
	always_ff @(posedge clk_in) begin
		if (lat.wr) begin
			mem_reg[lat.waddr] <= lat.wdata;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			valid_reg <= '0;
		end else if (lat.clr) begin
			valid_reg <= '0;
		end else if (lat.wr) begin
			valid_reg[lat.waddr] <= 1'b1;
		end
	end

	// unloaded bytes program as the erased value
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			lat.rdata <= ERASED_BYTE;
		end else if (valid_reg[lat.raddr]) begin
			lat.rdata <= mem_reg[lat.raddr];
		end else begin
			lat.rdata <= ERASED_BYTE;
		end
	end
endmodule : column_latch

// ===== sim/fpc_monitor.sv
// port-level assertions for the flash programming controller
`timescale 1ns/1ns
module fpc_monitor (
	input wire logic MCLK_IN, // clock
	input wire logic RESETN_IN, // reset
	input wire logic INSTR_DONE_IN, // end of instruction
	input wire logic SFR_WR_IN, // reg strobe
	input wire logic [7:0] SFR_ADDR_IN, // reg address
	input wire logic [7:0] SFR_WDATA_IN, // reg data
	input wire logic EXEC_BOOT_IN, // boot fetch
	input wire logic XDATA_WR_IN, // pointer write
	input wire logic [15:0] XDATA_ADDR_IN, // pointer
	input wire logic ARRAY_DONE_IN, // array done
	input wire logic [7:0] SEC_CURRENT_IN, // security now
	input wire logic [7:0] SEC_ERASED_IN, // erased bits
	input wire logic XDATA_TO_LATCH_OUT, // latch map
	input wire logic XDATA_TO_XRAM_OUT, // xram map
	input wire logic CODE_READ_BOOT_OUT, // boot reads
	input wire logic PROG_START_OUT, // launch
	input wire logic [2:0] PROG_OP_OUT, // operation
	input wire logic [flash_ctl_pkg::PAGE_W-1:0] PROG_PAGE_OUT, // page
	input wire logic PROG_UPPER_OUT, // upper half
	input wire logic [7:0] SEC_VALUE_OUT // security value
);
	import flash_ctl_pkg::*;
	default clocking @(posedge MCLK_IN);
	endclocking
	default disable iff (!RESETN_IN);
	logic ctl_wr;
	logic arm_reg;
	logic busy_reg;
	logic busy_now;
	logic [2:0] mode_reg;
	assign ctl_wr = INSTR_DONE_IN & SFR_WR_IN & (SFR_ADDR_IN == CONTROL_ADDR);
	assign busy_now = PROG_START_OUT | busy_reg;
	// arm state survives idle cycles, only the next instruction counts
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN)
			arm_reg <= 1'b0;
		else if (INSTR_DONE_IN)
			arm_reg <= ctl_wr && SFR_WDATA_IN[7:4] == NIBBLE_ARM;
	end
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN)
			mode_reg <= 3'h0;
		else if (ctl_wr)
			mode_reg <= SFR_WDATA_IN[2:0];
	end
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN)
			busy_reg <= 1'b0;
		else if (PROG_START_OUT)
			busy_reg <= 1'b1;
		else if (ARRAY_DONE_IN)
			busy_reg <= 1'b0;
	end
	a_launch_after_arm: assert property (PROG_START_OUT |->
		$past(arm_reg) &&
		$past(ctl_wr && SFR_WDATA_IN[7:4] == NIBBLE_LAUNCH))
		else $error("launch without a clean arm then launch pair");
	a_start_one_cycle: assert property (PROG_START_OUT |=>
		!PROG_START_OUT)
		else $error("launch pulse longer than one cycle");
	a_op_from_mode: assert property (PROG_START_OUT |->
		PROG_OP_OUT == (mode_reg < 3'h3 ? mode_reg + 3'h1 : mode_reg))
		else $error("operation does not match final mode");
	a_mode_allowed: assert property (PROG_START_OUT |->
		mode_reg inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5})
		else $error("launch in a mode that runs nothing");
	a_sec_erased_only: assert property (PROG_START_OUT &&
		PROG_OP_OUT == OP_SECURITY |-> (SEC_VALUE_OUT &
		~$past(SEC_CURRENT_IN) & ~$past(SEC_ERASED_IN)) == 8'h00)
		else $error("security value raises a bit not erased");
	a_latch_over_xram: assert property (XDATA_TO_LATCH_OUT |->
		!XDATA_TO_XRAM_OUT)
		else $error("xram select not overridden by latch map");
	a_boot_redirect: assert property (CODE_READ_BOOT_OUT |->
		$past(EXEC_BOOT_IN))
		else $error("boot reads outside boot execution");
	a_page_from_load: assert property (XDATA_WR_IN &&
		XDATA_TO_LATCH_OUT && !busy_now |=>
		PROG_PAGE_OUT == $past(XDATA_ADDR_IN[14:7]) &&
		PROG_UPPER_OUT == $past(XDATA_ADDR_IN[15]))
		else $error("target page not from last load");
	a_busy_frozen: assert property (XDATA_WR_IN && busy_now |=>
		$stable(PROG_PAGE_OUT) && $stable(PROG_UPPER_OUT))
		else $error("latch load accepted while busy");
	c_launch: cover property (PROG_START_OUT);
	c_security: cover property (PROG_START_OUT && PROG_OP_OUT == OP_SECURITY);
	c_load_busy: cover property (XDATA_WR_IN && busy_now);
endmodule : fpc_monitor
bind flash_page_program_control fpc_monitor mon_u (.MCLK_IN, .RESETN_IN,
	.INSTR_DONE_IN, .SFR_WR_IN, .SFR_ADDR_IN, .SFR_WDATA_IN, .EXEC_BOOT_IN,
	.XDATA_WR_IN, .XDATA_ADDR_IN, .ARRAY_DONE_IN, .SEC_CURRENT_IN,
	.SEC_ERASED_IN, .XDATA_TO_LATCH_OUT, .XDATA_TO_XRAM_OUT,
	.CODE_READ_BOOT_OUT, .PROG_START_OUT, .PROG_OP_OUT, .PROG_PAGE_OUT,
	.PROG_UPPER_OUT, .SEC_VALUE_OUT);

// ===== sim/cpu_model.sv
// core-side model: one instruction per call, register and pointer writes
`timescale 1ns/1ns
module cpu_model (
	input wire logic clk_in, // clock
	input wire logic [7:0] rdata_in, // reg read data
	output logic done_out, // end of instruction
	output logic sfr_wr_out, // reg strobe
	output logic [7:0] sfr_addr_out, // reg address
	output logic [7:0] sfr_data_out, // reg data
	output logic xd_wr_out, // pointer write
	output logic [15:0] xd_addr_out, // pointer
	output logic [7:0] xd_data_out // write byte
);
	initial begin
		{done_out, sfr_wr_out, xd_wr_out} = 3'h0;
		{sfr_addr_out, sfr_data_out, xd_data_out} = 24'h0000_00;
		xd_addr_out = 16'h0000;
	end
	// released data lines flip so a stale value is never mistaken for live
	task automatic idle;
		@(posedge clk_in);
		{done_out, sfr_wr_out, xd_wr_out} <= 3'h0;
		sfr_data_out <= ~sfr_data_out;
		xd_data_out <= ~xd_data_out;
	endtask : idle
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		{sfr_addr_out, sfr_data_out} <= {a, d};
		{done_out, sfr_wr_out} <= 2'h3;
		idle();
	endtask : sfr_write
	// only the pointer form reaches the latches
	task automatic xd_write(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		{xd_addr_out, xd_data_out} <= {a, d};
		{done_out, xd_wr_out} <= 2'h3;
		idle();
	endtask : xd_write
	// any other instruction between the two launch writes
	task automatic nop;
		@(posedge clk_in);
		done_out <= 1'b1;
		idle();
	endtask : nop
	task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		sfr_addr_out <= a;
		repeat (2) @(posedge clk_in);
		#1 d = rdata_in;
	endtask : sfr_read
endmodule : cpu_model

// ===== sim/flash_page_program_control_bench.sv
// self-checking bench for the flash programming controller
`timescale 1ns/1ns
module flash_page_program_control_bench;
	import flash_ctl_pkg::*;
	localparam int WATCH_CYCLES = 20000;
	logic MCLK_IN, RESETN_IN, BOOT_ENTRY_IN, EXEC_BOOT_IN, INSTR_DONE_IN;
	logic SFR_WR_IN, XDATA_WR_IN, XRAM_SELECT_IN, ARRAY_DONE_IN;
	logic XDATA_TO_LATCH_OUT, XDATA_TO_XRAM_OUT, CODE_READ_BOOT_OUT;
	logic PROG_START_OUT, PROG_UPPER_OUT;
	logic [7:0] SFR_ADDR_IN, SFR_WDATA_IN, SFR_RDATA_OUT, XDATA_DATA_IN;
	logic [7:0] LATCH_RD_DATA_OUT, SEC_CURRENT_IN, SEC_ERASED_IN, SEC_VALUE_OUT;
	logic [7:0] PROG_PAGE_OUT;
	logic [15:0] XDATA_ADDR_IN;
	logic [2:0] BANK_OVERRIDE_IN, MAP_MODE_OUT, PROG_OP_OUT, PROG_BANK_OUT;
	logic [6:0] LATCH_RD_ADDR_IN;
	logic [7:0] v;
	int errors = 0;
	int n_compared = 0;
	int starts = 0;
	int rd = 1, er = 0, ld = 0, by = 0, bank = 0, page = 0, ub = 0, s0;
	int lat[128];
	flash_page_program_control dut_u (.MCLK_IN, .RESETN_IN, .BOOT_ENTRY_IN,
		.EXEC_BOOT_IN, .INSTR_DONE_IN, .SFR_WR_IN, .SFR_ADDR_IN, .SFR_WDATA_IN,
		.SFR_RDATA_OUT, .XDATA_WR_IN, .XDATA_ADDR_IN, .XDATA_DATA_IN,
		.XRAM_SELECT_IN, .BANK_OVERRIDE_IN, .XDATA_TO_LATCH_OUT,
		.XDATA_TO_XRAM_OUT, .CODE_READ_BOOT_OUT, .MAP_MODE_OUT, .PROG_START_OUT,
		.PROG_OP_OUT, .PROG_PAGE_OUT, .PROG_BANK_OUT, .PROG_UPPER_OUT,
		.ARRAY_DONE_IN, .LATCH_RD_ADDR_IN, .LATCH_RD_DATA_OUT, .SEC_CURRENT_IN,
		.SEC_ERASED_IN, .SEC_VALUE_OUT);
	cpu_model cpu_u (.clk_in(MCLK_IN), .rdata_in(SFR_RDATA_OUT),
		.done_out(INSTR_DONE_IN), .sfr_wr_out(SFR_WR_IN),
		.sfr_addr_out(SFR_ADDR_IN), .sfr_data_out(SFR_WDATA_IN),
		.xd_wr_out(XDATA_WR_IN), .xd_addr_out(XDATA_ADDR_IN),
		.xd_data_out(XDATA_DATA_IN));
	initial begin
		MCLK_IN = 1'b0;
		forever #5 MCLK_IN = ~MCLK_IN;
	end
	always @(posedge MCLK_IN) if (PROG_START_OUT === 1'b1) starts++;
	task automatic test_done;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask : chk
	task automatic st_chk;
		cpu_u.sfr_read(STATUS_ADDR, v);
		chk("status", {rd[0], 4'h0, er[0], ld[0], by[0]}, v);
	endtask : st_chk
	// model keeps the latch image; loads while busy change nothing
	task automatic ld_byte(input logic [15:0] a);
		logic [7:0] d;
		d = 8'($urandom);
		cpu_u.xd_write(a, d);
		if (by == 0) begin
			lat[a[6:0]] = d;
			ld = 1;
			page = a[14:7];
			ub = a[15];
			if (a[15]) bank = BANK_OVERRIDE_IN;
		end
	endtask : ld_byte
	initial begin
		s0 = $urandom(32'h803f);
		{RESETN_IN, BOOT_ENTRY_IN, EXEC_BOOT_IN, XRAM_SELECT_IN} = 4'h7;
		{ARRAY_DONE_IN, BANK_OVERRIDE_IN, LATCH_RD_ADDR_IN} = 11'h000;
		{SEC_CURRENT_IN, SEC_ERASED_IN} = 16'h0000;
		repeat (20) @(posedge MCLK_IN);
		RESETN_IN <= 1'b1;
		repeat (2) @(posedge MCLK_IN);
		st_chk();
		cpu_u.sfr_read(CONTROL_ADDR, v);
		chk("control", CONTROL_RESET, v);
		cpu_u.sfr_read(8'h00, v);
		chk("unmapped", READ_ZERO, v);
		chk("to_xram", 8'h01, 8'(XDATA_TO_XRAM_OUT));
		@(posedge MCLK_IN);
		XRAM_SELECT_IN <= 1'b0;
		repeat (2) @(posedge MCLK_IN);
		#1 chk("to_xram", 8'h00, 8'(XDATA_TO_XRAM_OUT));
		@(posedge MCLK_IN);
		XRAM_SELECT_IN <= 1'b1;
		for (int b = 0; b < 3; b++) begin
			@(posedge MCLK_IN);
			EXEC_BOOT_IN <= (b > 0);
			cpu_u.sfr_write(STATUS_ADDR, b == 2 ? 8'h80 : 8'h00);
			rd = (b != 1);
			st_chk();
			chk("boot_read", 8'(b == 2), 8'(CODE_READ_BOOT_OUT));
		end
		cpu_u.sfr_write(CONTROL_ADDR, 8'h50);
		cpu_u.sfr_write(CONTROL_ADDR, 8'ha0);
		er = 1;
		st_chk();
		cpu_u.sfr_write(STATUS_ADDR, 8'h80);
		er = 0;
		st_chk();
		for (int m = 0; m < 8; m++) begin
			cpu_u.sfr_write(CONTROL_ADDR, 8'h08);
			cpu_u.xd_write(16'h0000, 8'h00);
			cpu_u.sfr_write(CONTROL_ADDR, 8'h5b);
			cpu_u.sfr_write(CONTROL_ADDR, 8'hab);
			{ld, er} = 2'h0;
			foreach (lat[i]) lat[i] = 255;
			chk("to_latch", 8'h01, 8'(XDATA_TO_LATCH_OUT));
			chk("to_xram", 8'h00, 8'(XDATA_TO_XRAM_OUT));
			@(posedge MCLK_IN);
			BANK_OVERRIDE_IN <= 3'($urandom);
			{SEC_CURRENT_IN, SEC_ERASED_IN} <= 16'($urandom);
			ld_byte({9'($urandom), 7'h00});
			s0 = $urandom_range(0, 511);
			repeat ($urandom_range(1, 4))
				ld_byte({9'(s0), 7'($urandom_range(1, 126))});
			for (int j = 0; j < 2; j++) begin
				@(posedge MCLK_IN);
				LATCH_RD_ADDR_IN <= j ? 7'h00 : 7'h7f;
				repeat (2) @(posedge MCLK_IN);
				#1 chk("latch", 8'(lat[j ? 0 : 127]), LATCH_RD_DATA_OUT);
			end
			chk("page", 8'(page), PROG_PAGE_OUT);
			chk("upper", 8'(ub), 8'(PROG_UPPER_OUT));
			chk("bank", 8'(bank), 8'(PROG_BANK_OUT));
			cpu_u.sfr_write(CONTROL_ADDR, {4'h5, 1'b1, 3'(m)});
			cpu_u.nop();
			cpu_u.sfr_write(CONTROL_ADDR, {4'ha, 1'b1, 3'(m)});
			er = 1;
			st_chk();
			s0 = starts;
			cpu_u.sfr_write(CONTROL_ADDR, {4'h5, 1'b1, 3'($urandom)});
			cpu_u.sfr_write(CONTROL_ADDR, {4'ha, 1'b1, 3'(m)});
			er = 0;
			if (m == 3 || m < 6)
				ld = 0;
			by = (m < 6 && m != 3);
			st_chk();
			chk("starts", 8'(s0 + by), 8'(starts));
			chk("mode", 8'(m), 8'(MAP_MODE_OUT));
			if (by) begin
				chk("op", 8'(m < 3 ? m + 1 : m), 8'(PROG_OP_OUT));
				if (m == 4)
					chk("security", SEC_CURRENT_IN |
						(8'(lat[0]) & SEC_ERASED_IN), SEC_VALUE_OUT);
				ld_byte(16'hff80);
				cpu_u.sfr_write(STATUS_ADDR, {rd[0], 7'h00});
				st_chk();
				chk("page_busy", 8'(page), PROG_PAGE_OUT);
				@(posedge MCLK_IN);
				ARRAY_DONE_IN <= 1'b1;
				@(posedge MCLK_IN);
				ARRAY_DONE_IN <= 1'b0;
				by = 0;
				st_chk();
			end
		end
		@(posedge MCLK_IN);
		{RESETN_IN, BOOT_ENTRY_IN} <= 2'h0;
		repeat (3) @(posedge MCLK_IN);
		RESETN_IN <= 1'b1;
		repeat (2) @(posedge MCLK_IN);
		rd = 0;
		ld = 0;
		st_chk();
		chk("op_reset", 8'h00, 8'(PROG_OP_OUT));
		chk("boot_read", 8'h00, 8'(CODE_READ_BOOT_OUT));
		cpu_u.sfr_read(CONTROL_ADDR, v);
		chk("control", CONTROL_RESET, v);
		test_done();
	end
	initial begin
		#(WATCH_CYCLES * 10);
		errors++;
		test_done();
	end
endmodule : flash_page_program_control_bench
